// ==== dibs_defines.svh ====
// constants for the dual i/o bus select sequencer
`ifndef DIBS_DEFINES_SVH
`define DIBS_DEFINES_SVH
`define DIBS_CLK_HZ 10000000
`define DIBS_PHI_HZ 2000000
`define DIBS_REG_CFG 8'h00
`define DIBS_REG_STAT 8'h04
`define DIBS_CFG_RST 10'h000
`define DIBS_CFG_A_LSB 0
`define DIBS_CFG_B_LSB 4
`define DIBS_CFG_SWAPSRC 8
`define DIBS_CFG_MODE2 9
`define DIBS_ROM_STAT_FN 4'h0
`define DIBS_ROM_PAR_FN 4'h7
`define DIBS_INTA_M0_FILL 8'hC7
`endif

// ==== dibs_pkg.sv ====
// types for the dual i/o bus select sequencer
package dibs_pkg;
  typedef enum logic [2:0] {
    DIBS_IDLE,
    DIBS_SYNC,
    DIBS_XFER,
    DIBS_RDY,
    DIBS_DONE
  } dibs_seq_t;

  typedef struct packed {
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [9:0] ctl1;
    logic [9:0] ctl2;
    logic [7:0] dout1;
    logic [7:0] dout2;
    logic [7:0] ib1;
    logic [7:0] ib2;
    logic m1_prev;
    logic [3:0] cnt;
    logic phi1;
    logic phi2;
    logic [9:0] cfg;
    logic sel_a;
    logic sel_b;
    logic rev;
    logic en_a;
    logic en_b;
    logic inta;
    logic rd_cyc;
    dibs_seq_t seq;
    logic ce_a;
    logic ce_b;
    logic [3:0] func;
    logic par_n;
    logic sync;
    logic [7:0] ibus_o;
    logic ibus_oe;
    logic d0a;
    logic d0b;
    logic gate;
    logic [7:0] din;
    logic din_oe;
    logic host_wait;
    logic pri_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dibs_state_t;
endpackage

// ==== dibs_fdec.sv ====
// function decode rom: controller function address and bus control strobes
`timescale 1ns/100ps
module dibs_fdec
  import dibs_pkg::*;
(
  input wire logic en,
  input wire logic [3:0] nib,
  input wire logic wo_n,
  output logic [3:0] func,
  output logic par_n,
  output logic stat_n,
  output logic wr_n,
  output logic rd_n
);
`include "dibs_defines.svh"

  always_comb begin
    func = en ? nib : 4'h0;
    par_n = !(en && nib == `DIBS_ROM_PAR_FN);
    stat_n = !(en && wo_n && nib == `DIBS_ROM_STAT_FN);
    wr_n = !(en && !wo_n);
    rd_n = !(en && wo_n);
  end
endmodule

// ==== dibs_top.sv ====
// bus select, phase clock, sequencer and priority glue for two i/o controllers
`timescale 1ns/100ps
module dibs_top
  import dibs_pkg::*;
#(
  parameter int CLK_HZ = `DIBS_CLK_HZ,
  parameter int PHI_HZ = `DIBS_PHI_HZ
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] s_addr,
  input wire logic s_out,
  input wire logic s_inp,
  input wire logic s_wo_n,
  input wire logic s_inta,
  input wire logic s_m1,
  input wire logic [7:0] s_dout,
  output logic [7:0] s_din,
  output logic s_din_oe,
  output logic host_wait,
  input wire logic pri_in,
  output logic pri_out,
  output logic phi1_clk,
  output logic phase_two_logic_clock,
  output logic ce_a,
  output logic ce_b,
  output logic [3:0] func_addr,
  output logic par_strobe_n,
  output logic chip_sync,
  input wire logic [7:0] ibus_i,
  output logic [7:0] ibus_o,
  output logic ibus_oe,
  output logic d0a,
  output logic d0b,
  output logic latch_gate,
  input wire logic int_req_a,
  input wire logic int_req_b,
  input wire logic rev_pin,
  input wire logic pa_msb
);
`include "dibs_defines.svh"

  localparam int DIV = CLK_HZ / PHI_HZ;
  localparam int HALF = (DIV - 1) / 2;
  localparam logic [3:0] CNT_LAST = 4'(DIV - 1);
  localparam logic [3:0] CNT_RISE = 4'(HALF - 1);
  localparam logic [3:0] CNT_FALL = 4'(2 * HALF - 1);
  localparam logic [3:0] CNT_HALF = 4'(HALF);
  localparam logic [3:0] CNT_TWO = 4'(2 * HALF);
  // synchronised control bit positions
  localparam int C_OUT = 0;
  localparam int C_INP = 1;
  localparam int C_WON = 2;
  localparam int C_INTA = 3;
  localparam int C_M1 = 4;
  localparam int C_PRI = 5;
  localparam int C_IRQA = 6;
  localparam int C_IRQB = 7;
  localparam int C_REV = 8;
  localparam int C_PAM = 9;

  if (DIV < 4 || DIV > 15) begin : g_div_check
    $error("board clock must be 4 to 15 times the phase clock");
  end

  function automatic logic addr_match(input logic [3:0] nib, input logic [3:0] sw);
    addr_match = &(~(nib ^ sw));
  endfunction

  // status bit select: identity arrangement of controller flags
  function automatic logic [7:0] stat_arrange(input logic [7:0] b);
    stat_arrange = b;
  endfunction

  dibs_state_t s;
  dibs_state_t next_s;
  logic [3:0] rom_func;
  logic rom_par_n;
  logic rom_stat_n;
  logic rom_wr_n;
  logic rom_rd_n;

  ////////////////////////////////////////////////////////////////////////////
  // function decode rom

  dibs_fdec i_dibs_fdec (
    .en(s.sel_a || s.sel_b),
    .nib(s.addr2[3:0]),
    .wo_n(s.ctl2[C_WON]),
    .func(rom_func),
    .par_n(rom_par_n),
    .stat_n(rom_stat_n),
    .wr_n(rom_wr_n),
    .rd_n(rom_rd_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic io;
    logic match_a;
    logic match_b;
    logic rise;
    logic fall;
    logic req;
    logic acc;
    logic swap_sel;
    io = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    req = 1'b0;
    acc = 1'b0;
    swap_sel = 1'b0;
    next_s = s;

    // two-flop synchronisers on every pin input except the apb bus
    next_s.addr1 = s_addr;
    next_s.addr2 = s.addr1;
    next_s.ctl1 = {pa_msb, rev_pin, int_req_b, int_req_a, pri_in, s_m1, s_inta, s_wo_n,
                   s_inp, s_out};
    next_s.ctl2 = s.ctl1;
    next_s.dout1 = s_dout;
    next_s.dout2 = s.dout1;
    next_s.ib1 = ibus_i;
    next_s.ib2 = s.ib1;
    next_s.m1_prev = s.ctl2[C_M1];

    // phase clock divider
    next_s.cnt = (s.cnt == CNT_LAST) ? 4'h0 : s.cnt + 4'h1;
    next_s.phi1 = next_s.cnt < CNT_HALF;
    next_s.phi2 = next_s.cnt >= CNT_HALF && next_s.cnt < CNT_TWO;
    rise = s.cnt == CNT_RISE;
    fall = s.cnt == CNT_FALL;

    // base address compare and exclusion
    io = s.ctl2[C_OUT] || s.ctl2[C_INP];
    match_a = addr_match(s.addr2[7:4], s.cfg[`DIBS_CFG_A_LSB +: 4]);
    match_b = addr_match(s.addr2[7:4], s.cfg[`DIBS_CFG_B_LSB +: 4]);
    next_s.sel_a = match_a && io;
    next_s.sel_b = match_b && io && !next_s.sel_a;

    // address reversal source and chip enables
    swap_sel = s.cfg[`DIBS_CFG_SWAPSRC] ? s.ctl2[C_PAM] : s.ctl2[C_REV];
    next_s.rev = !swap_sel;
    next_s.ce_a = swap_sel ? s.sel_a : s.sel_b;
    next_s.ce_b = swap_sel ? s.sel_b : s.sel_a;

    // priority chain: chip enables resolved at each machine cycle one, priority out and acknowledge updated every clock
    if (s.ctl2[C_M1] && !s.m1_prev) begin
      next_s.en_a = s.ctl2[C_IRQA] && s.ctl2[C_PRI];
      next_s.en_b = s.ctl2[C_IRQB] && s.ctl2[C_PRI] && !s.ctl2[C_IRQA];
    end
    next_s.pri_out = s.ctl2[C_PRI] && !s.ctl2[C_IRQA] && !s.ctl2[C_IRQB];
    next_s.inta = s.ctl2[C_INTA] && (s.en_a || s.en_b);

    // function rom outputs
    next_s.func = rom_func;
    next_s.par_n = rom_par_n;
    next_s.rd_cyc = !rom_rd_n;

    // sequencer
    req = s.sel_a || s.sel_b || s.inta;
    if (!req) begin
      next_s.seq = DIBS_IDLE;
    end else begin
      unique case (s.seq)
        DIBS_IDLE: begin
          if (fall) begin
            next_s.seq = DIBS_SYNC;
          end
        end
        DIBS_SYNC: begin
          if (rise) begin
            next_s.seq = DIBS_XFER;
          end
        end
        DIBS_XFER: begin
          if (fall) begin
            next_s.seq = DIBS_RDY;
          end
        end
        DIBS_RDY: begin
          if (rise) begin
            next_s.seq = DIBS_DONE;
          end
        end
        DIBS_DONE: begin
          next_s.seq = DIBS_DONE;
        end
      endcase
    end
    next_s.sync = next_s.seq == DIBS_SYNC;

    // internal bus: status during sync, host data during write transfer
    next_s.ibus_oe = 1'b0;
    next_s.ibus_o = 8'h00;
    next_s.d0a = 1'b0;
    next_s.d0b = 1'b0;
    if (next_s.seq == DIBS_SYNC) begin
      next_s.ibus_oe = 1'b1;
      next_s.ibus_o = {6'h00, !rom_rd_n, 1'b0};
      next_s.d0a = s.inta && s.en_a;
      next_s.d0b = s.inta && s.en_b;
    end else if (next_s.seq != DIBS_IDLE && !rom_wr_n) begin
      next_s.ibus_oe = 1'b1;
      next_s.ibus_o = s.dout2;
      next_s.d0a = s.dout2[0];
      next_s.d0b = s.dout2[0];
    end

    // read latch path select
    next_s.gate = next_s.seq == DIBS_RDY;
    if (s.seq == DIBS_RDY) begin
      if (s.inta) begin
        next_s.din = s.cfg[`DIBS_CFG_MODE2] ?
            {s.cfg[`DIBS_CFG_A_LSB + 1 +: 3], s.en_b, s.ib2[5:3], 1'b0} :
            (`DIBS_INTA_M0_FILL | {2'b00, s.ib2[5:3], 3'b000});
      end else if (!rom_stat_n) begin
        next_s.din = stat_arrange(s.ib2);
      end else begin
        next_s.din = s.ib2;
      end
    end
    next_s.din_oe = (s.ctl2[C_INP] && (s.sel_a || s.sel_b)) || s.inta;
    next_s.host_wait = req && next_s.seq != DIBS_RDY && next_s.seq != DIBS_DONE;

    // apb slave: answer in the first access cycle
    acc = psel && penable && s.pready;
    if (acc && pwrite && paddr == `DIBS_REG_CFG) begin
      next_s.cfg = pwdata[9:0];
    end
    next_s.pready = psel && !penable;
    next_s.pslverr = psel && !penable && paddr != `DIBS_REG_CFG && paddr != `DIBS_REG_STAT;
    next_s.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == `DIBS_REG_CFG) begin
        next_s.prdata = {22'h000000, s.cfg};
      end else if (paddr == `DIBS_REG_STAT) begin
        next_s.prdata = {22'h000000, s.rev, s.inta, s.en_b, s.en_a, s.sel_b, s.sel_a,
                         s.host_wait, s.seq};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.cfg <= `DIBS_CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign s_din = s.din;
  assign s_din_oe = s.din_oe;
  assign host_wait = s.host_wait;
  assign pri_out = s.pri_out;
  assign phi1_clk = s.phi1;
  assign phase_two_logic_clock = s.phi2;
  assign ce_a = s.ce_a;
  assign ce_b = s.ce_b;
  assign func_addr = s.func;
  assign par_strobe_n = s.par_n;
  assign chip_sync = s.sync;
  assign ibus_o = s.ibus_o;
  assign ibus_oe = s.ibus_oe;
  assign d0a = s.d0a;
  assign d0b = s.d0b;
  assign latch_gate = s.gate;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  localparam int PDIV = DIV;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_phase;
    $rose(phase_two_logic_clock) |-> ##PDIV $rose(phase_two_logic_clock);
  endproperty
  a_phase: assert property (p_phase) else $error("phase clock period wrong");

  property p_nonoverlap;
    !(phi1_clk && phase_two_logic_clock);
  endproperty
  a_nonoverlap: assert property (p_nonoverlap) else $error("phase clocks overlap");

  property p_excl;
    !(ce_a && ce_b);
  endproperty
  a_excl: assert property (p_excl) else $error("both chip enables active");

  property p_sel_io;
    (s.sel_a || s.sel_b) |-> ($past(s.ctl2[C_OUT]) || $past(s.ctl2[C_INP]));
  endproperty
  a_sel_io: assert property (p_sel_io) else $error("select without io status");

  property p_rom;
    !(s.sel_a || s.sel_b) |=> func_addr == 4'h0;
  endproperty
  a_rom: assert property (p_rom) else $error("rom active without select");

  property p_sync_len;
    $rose(chip_sync) |-> ##3 !chip_sync;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync pulse too long");

  property p_sync_bus;
    chip_sync |-> ibus_oe && !latch_gate;
  endproperty
  a_sync_bus: assert property (p_sync_bus) else $error("status not driven in sync");

  property p_prio;
    chip_sync |-> !(d0a && d0b);
  endproperty
  a_prio: assert property (p_prio) else $error("both chips acknowledged");

  property p_wait;
    $rose(chip_sync) |-> host_wait ##[1:10] !host_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("ready not released");

  property p_idle;
    s.seq == DIBS_IDLE |-> !ibus_oe && !d0a && !d0b && !chip_sync && !latch_gate;
  endproperty
  a_idle: assert property (p_idle) else $error("driver active while idle");

  c_write: cover property ($rose(chip_sync) && !ibus_o[1] && !d0a && !d0b);
  c_read: cover property ($rose(latch_gate) && s_din_oe && !s.inta);
  c_inta: cover property ($rose(chip_sync) && d0a);
  c_swap: cover property (s.rev && ce_b);
endmodule

// ==== dibs_host_model.sv ====
// host model issuing i/o and acknowledge cycles
`timescale 1ns/100ps
module dibs_host_model (
  input wire logic clk,
  input wire logic host_wait,
  input wire logic [7:0] s_din,
  output logic [7:0] s_addr,
  output logic s_out,
  output logic s_inp,
  output logic s_wo_n,
  output logic s_inta,
  output logic s_m1,
  output logic [7:0] s_dout
);
  initial begin
    {s_addr, s_out, s_inp, s_inta, s_m1, s_dout} = '0;
    s_wo_n = 1'b1;
  end
  // kind 0 write, 1 read, 2 acknowledge; slow adds cycles before ending
  task automatic cycle(input int kind, input logic [7:0] a, input logic [7:0] d,
                       input int slow, output logic [7:0] rd);
    int n;
    repeat (6) @(posedge clk);
    s_addr <= a;
    s_dout <= d;
    s_wo_n <= (kind != 0);
    s_m1 <= (kind == 2);
    @(posedge clk);
    s_out <= (kind == 0);
    s_inp <= (kind == 1);
    s_inta <= (kind == 2);
    n = 0;
    // status held until the board releases wait
    while (host_wait !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (host_wait === 1'b1) begin
      @(posedge clk);
    end
    repeat (3 + slow) @(posedge clk);
    rd = s_din;
    {s_out, s_inp, s_inta, s_m1} <= '0;
    s_addr <= ~a;
    s_dout <= ~d;
  endtask
endmodule

// ==== dibs_top_tb.sv ====
// testbench for the dual i/o bus select sequencer
`timescale 1ns/100ps
module dibs_top_tb;
  import dibs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr, s_addr, s_dout, s_din, ibus_i, ibus_o, rd;
  logic psel, penable, pwrite, pready, pslverr, s_out, s_inp, s_wo_n, s_inta, s_m1;
  logic [31:0] pwdata, prdata, r;
  logic s_din_oe, host_wait, pri_in, pri_out, phi1_clk, phase_two_logic_clock;
  logic ce_a, ce_b, par_strobe_n, chip_sync, ibus_oe, d0a, d0b, latch_gate;
  logic int_req_a, int_req_b, rev_pin, pa_msb, e, sy_q, phi2_q, lg_q;
  logic ovl = 1'b0;
  logic [3:0] func_addr, sy_fn;
  logic [1:0] sy_ce, sy_st, sy_d0;
  logic [7:0] sy_xd;
  logic [2:0] sy_ph;
  int n_sync = 0;
  int n_phi = 0;
  int n_act = 0;
  int n_gate = 0;
  int p0, ns, ng;
  int mismatches = 0;
  int checks_done = 0;

  always #50 clk = ~clk;

  dibs_top i_dibs_top (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .s_addr, .s_out, .s_inp, .s_wo_n, .s_inta, .s_m1, .s_dout, .s_din,
    .s_din_oe, .host_wait, .pri_in, .pri_out, .phi1_clk, .phase_two_logic_clock, .ce_a,
    .ce_b, .func_addr, .par_strobe_n, .chip_sync, .ibus_i, .ibus_o, .ibus_oe, .d0a, .d0b,
    .latch_gate, .int_req_a, .int_req_b, .rev_pin, .pa_msb);

  dibs_host_model i_host (.clk, .host_wait, .s_din, .s_addr, .s_out, .s_inp, .s_wo_n,
    .s_inta, .s_m1, .s_dout);

  ////////////////////////////////////////////////////////////////////////////////
  // capture what the chips see at sync and transfer time
  always @(posedge clk) begin
    sy_q <= chip_sync;
    lg_q <= latch_gate;
    if (latch_gate === 1'b1 && lg_q === 1'b0) n_gate <= n_gate + 1;
    ovl <= ovl | (phi1_clk & phase_two_logic_clock);
    if (phase_two_logic_clock === 1'b1 && phi2_q === 1'b0) n_phi <= n_phi + 1;
    if (host_wait | ce_a | ce_b | ibus_oe | chip_sync | (func_addr != 4'h0)) begin
      n_act <= n_act + 1;
    end
    if (chip_sync === 1'b1 && sy_q === 1'b0) begin
      sy_ce <= {ce_a, ce_b};
      sy_fn <= func_addr;
      sy_st <= ibus_o[1:0];
      sy_d0 <= {d0a, d0b};
      sy_ph <= {par_strobe_n, s_din_oe, host_wait};
      n_sync <= n_sync + 1;
    end
    if (chip_sync === 1'b0 && sy_q === 1'b1) sy_xd <= ibus_o;
  end
  always @(posedge clk) phi2_q <= phase_two_logic_clock;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {paddr, psel, penable, pwrite, pwdata, int_req_a, int_req_b, pa_msb} = '0;
    ibus_i = 8'h96;
    pri_in = 1'b1;
    rev_pin = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(0, 8'h00, 0);
    chk(r, 32'h0);
    apb(0, 8'h04, 0);
    chk(r, 32'h0);
    apb(0, 8'h08, 0);
    chk(r, 32'h0);
    chk(e, 1'b1);
    apb(1, 8'h00, 32'h5A);
    apb(0, 8'h00, 0);
    chk(r, 32'h5A);
    chk(pri_out, 1'b1);
    p0 = n_phi;
    repeat (100) @(posedge clk);
    chk(n_phi - p0, 20);
    chk(ovl, 1'b0);
    ns = n_sync;
    ng = n_gate;
    i_host.cycle(0, 8'hA3, 8'hC4, 0, rd);
    chk(n_sync - ns, 1);
    chk(n_gate - ng, 1);
    chk(sy_ph, 3'b101);
    chk({sy_ce, sy_fn, sy_st[1]}, {2'b10, 4'h3, 1'b0});
    chk(sy_xd, 8'hC4);
    i_host.cycle(1, 8'h57, 8'h00, 5, rd);
    chk({sy_ce, sy_fn, sy_st[1]}, {2'b01, 4'h7, 1'b1});
    chk(rd, 8'h96);
    chk(sy_ph, 3'b011);
    repeat (8) @(posedge clk);
    p0 = n_act;
    i_host.cycle(0, 8'h33, 8'h11, 0, rd);
    chk(n_act - p0, 0);
    apb(1, 8'h00, 32'hAA);
    i_host.cycle(0, 8'hA1, 8'h3C, 0, rd);
    chk(sy_ce, 2'b10);
    rev_pin <= 1'b0;
    i_host.cycle(0, 8'hA2, 8'h3C, 0, rd);
    chk(sy_ce, 2'b01);
    apb(1, 8'h00, 32'h1AA);
    pa_msb <= 1'b1;
    i_host.cycle(0, 8'hA2, 8'h3C, 0, rd);
    chk(sy_ce, 2'b10);
    pa_msb <= 1'b0;
    i_host.cycle(0, 8'hA2, 8'h3C, 0, rd);
    chk(sy_ce, 2'b01);
    rev_pin <= 1'b1;
    apb(1, 8'h00, 32'h5A);
    int_req_a <= 1'b1;
    int_req_b <= 1'b1;
    i_host.cycle(2, 8'hFF, 8'h00, 0, rd);
    chk(sy_d0, 2'b10);
    chk(rd, 8'hD7);
    chk(sy_ph, 3'b111);
    chk(pri_out, 1'b0);
    int_req_a <= 1'b0;
    i_host.cycle(2, 8'hFF, 8'h00, 0, rd);
    chk(sy_d0, 2'b01);
    repeat (10) @(posedge clk);
    wrap_up();
  end
endmodule
